// ### iowf_flags.sv
// Wake-up event flag register with APB access, masking and interrupt.
// Notes on behaviour
// - Bit 0 sets on wake_input_1 level wake or cyclic state change.
// - Bit 1 sets on wake_input_2 level wake or cyclic state change.
// - Event flags clear on reset, fail-safe entry, or written one.
// - Bit 2 holds wake_input_1 level from latest trigger point.
// - Bit 3 holds wake_input_2 level from latest trigger point.
// - Bit 4 shows wake_input_1 cyclic sense ready; follows cyc_ready[0] every cycle.
// - Bit 5 shows wake_input_2 cyclic sense ready; follows cyc_ready[1] every cycle.
// - Bit 6 sets on hv_io_1_a level wake or cyclic state change.
// - Bit 7 sets on hv_io_2_b level wake or cyclic state change.
// - Bit 8 holds hv_io_1_a level from latest trigger point.
// - Bit 9 holds hv_io_2_b level from latest trigger point.
// - Bit 10 shows hv_io_1_a cyclic sense ready.
// - Bit 11 shows hv_io_2_b cyclic sense ready.
// - Bit 13 sets when lv_io_3_c wakes outside Normal mode.
// - Bit 14 sets when lv_io_4_d wakes outside Normal mode.
// - Bit 15 sets when lv_in_5 wakes outside Normal mode.
// - Two-bit field: none, wake only, interrupt only, or both.
`timescale 1ns/1ps
module iowf_flags #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Wake pins: wake_input_1, wake_input_2, hv_io_1_a, hv_io_2_b,
   // lv_io_3_c, lv_io_4_d, lv_in_5 in that order
   input wire logic [6:0] wake_pin,
   // Cyclic sense and mode status from on-chip logic
   input wire logic [3:0] cyc_mode,
   input wire logic [3:0] cyc_trig,
   input wire logic [3:0] cyc_ready,
   input wire logic normal_mode,
   input wire logic fail_safe_entry,
   // Requests
   output logic wake_req,
   output logic irq
);

   // The decoder reads the full low byte, so narrower buses cannot work.
   if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8 to decode the register map.");
   end

   typedef struct packed {
      logic [6:0] sync1;
      logic [6:0] sync2;
      logic [15:0] flags;
      logic [13:0] cfg;
      logic [15:0] mask;
      logic [6:0] pol;
      logic [3:0] primed;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic wake_req;
      logic irq;
   } iowf_state_t;

   iowf_state_t st_q;
   iowf_state_t st_d;

   // Returns the two-bit wake configuration of one input.
   function automatic logic [1:0] wcfg(input logic [13:0] cfg, input int i);
      wcfg = cfg[2*i +: 2];
   endfunction : wcfg

   // Matches the low byte of the bus address against a register offset.
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] off);
      hit = (a[7:0] == off) && (a[ADDR_W-1:0] >> 8 == '0);
   endfunction : hit

   logic acc_phase;
   logic wr_done;
   logic addr_ok;
   logic [15:0] set_v;
   logic [15:0] clr_v;
   logic [15:0] irq_en;
   logic [15:0] wake_en;

   assign acc_phase = psel && penable;
   assign wr_done = acc_phase && st_q.pready && pwrite;
   assign addr_ok = hit(paddr, iowf_pkg::ADDR_FLAGS) ||
                    hit(paddr, iowf_pkg::ADDR_CFG) ||
                    hit(paddr, iowf_pkg::ADDR_MASK) ||
                    hit(paddr, iowf_pkg::ADDR_POL);

   always_comb begin
      logic lvl;
      logic chg;
      st_d = st_q;
      lvl = 1'b0;
      chg = 1'b0;
      set_v = '0;
      clr_v = '0;
      irq_en = '0;
      wake_en = '0;

      // The first stage feeds only the second; logic reads sync2.
      st_d.sync1 = wake_pin;
      st_d.sync2 = st_q.sync1;

      // Event sources on the high-voltage inputs.
      for (int i = 0; i < iowf_pkg::N_CYC; i++) begin
         lvl = st_q.sync2[i] ^ st_q.pol[i];
         chg = st_q.primed[i] &&
               (st_q.sync2[i] != st_q.flags[iowf_pkg::SMP_BIT[i]]);
         if (wcfg(st_q.cfg, i) != iowf_pkg::WCFG_NONE) begin
            if (cyc_mode[i]) begin
               // Compare with the sample of the previous trigger point.
               if (cyc_trig[i] && chg) begin
                  set_v[iowf_pkg::EVT_BIT[i]] = 1'b1;
               end
            end else if (lvl) begin
               set_v[iowf_pkg::EVT_BIT[i]] = 1'b1;
            end
         end
         if (cyc_trig[i]) begin
            st_d.flags[iowf_pkg::SMP_BIT[i]] = st_q.sync2[i];
            st_d.primed[i] = 1'b1;
         end
         // Readiness mirrors the timer logic and clears whenever cyc_ready drops.
         st_d.flags[iowf_pkg::RDY_BIT[i]] =
            cyc_ready[i];
      end

      // Low-voltage inputs report only wakes from low-power modes.
      for (int i = iowf_pkg::N_CYC; i < iowf_pkg::N_IN; i++) begin
         lvl = st_q.sync2[i] ^ st_q.pol[i];
         if (lvl && !normal_mode &&
             wcfg(st_q.cfg, i) != iowf_pkg::WCFG_NONE) begin
            set_v[iowf_pkg::EVT_BIT[i]] = 1'b1;
         end
      end

      // Per-flag enables for the wake and interrupt paths.
      for (int i = 0; i < iowf_pkg::N_IN; i++) begin
         irq_en[iowf_pkg::EVT_BIT[i]] =
            st_q.cfg[2*i + iowf_pkg::WCFG_IRQ_BIT];
         wake_en[iowf_pkg::EVT_BIT[i]] =
            st_q.cfg[2*i + iowf_pkg::WCFG_WAKE_BIT];
      end

      // APB: one wait state, then the write lands and read data is held.
      st_d.pready = acc_phase && !st_q.pready;
      st_d.pslverr = acc_phase && !st_q.pready && !addr_ok;
      if (acc_phase && !st_q.pready && !pwrite) begin
         if (hit(paddr, iowf_pkg::ADDR_FLAGS)) begin
            st_d.prdata = {16'h0000, st_q.flags};
         end else if (hit(paddr, iowf_pkg::ADDR_CFG)) begin
            st_d.prdata = {18'h0, st_q.cfg};
         end else if (hit(paddr, iowf_pkg::ADDR_MASK)) begin
            st_d.prdata = {16'h0000, st_q.mask};
         end else if (hit(paddr, iowf_pkg::ADDR_POL)) begin
            st_d.prdata = {25'h0, st_q.pol};
         end else begin
            st_d.prdata = 32'h00000000;
         end
      end
      if (wr_done) begin
         if (hit(paddr, iowf_pkg::ADDR_FLAGS)) begin
            // Only event positions react, and only to ones.
            clr_v = pwdata[15:0] & iowf_pkg::FLG_EVT_MASK;
         end
         if (hit(paddr, iowf_pkg::ADDR_CFG)) begin
            st_d.cfg = pwdata[13:0];
         end
         if (hit(paddr, iowf_pkg::ADDR_MASK)) begin
            st_d.mask = pwdata[15:0] & iowf_pkg::FLG_EVT_MASK;
         end
         if (hit(paddr, iowf_pkg::ADDR_POL)) begin
            st_d.pol = pwdata[6:0];
         end
      end

      // A new event beats a software clear in the same cycle, so no
      // wake is lost; fail-safe entry clears unconditionally.
      st_d.flags = (st_d.flags & ~(clr_v & ~set_v)) | set_v;
      if (fail_safe_entry) begin
         st_d.flags = st_d.flags & ~iowf_pkg::FLG_EVT_MASK;
         st_d.cfg = (st_d.cfg & ~iowf_pkg::CFG_FS_MASK) |
                    (iowf_pkg::CFG_RESET & iowf_pkg::CFG_FS_MASK);
      end
      st_d.flags[iowf_pkg::UNUSED_BIT] = 1'b0;

      st_d.irq = |(st_d.flags & iowf_pkg::FLG_EVT_MASK & st_d.mask & irq_en);
      st_d.wake_req = |(st_d.flags & iowf_pkg::FLG_EVT_MASK & wake_en);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= '{sync1: 7'h00, sync2: 7'h00,
                   flags: iowf_pkg::FLG_RESET, cfg: iowf_pkg::CFG_RESET,
                   mask: iowf_pkg::MASK_RESET, pol: iowf_pkg::POL_RESET,
                   primed: 4'h0, pready: 1'b0, prdata: 32'h00000000,
                   pslverr: 1'b0, wake_req: 1'b0, irq: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign pready = st_q.pready;
   assign prdata = st_q.prdata;
   assign pslverr = st_q.pslverr;
   assign irq = st_q.irq;
   assign wake_req = st_q.wake_req;

   // Checks on the flag behaviour.

   AST_W1_LEVEL: assert property (@(posedge mclk) disable iff (sys_rst)
      (!cyc_mode[0] && st_q.cfg[1:0] != iowf_pkg::WCFG_NONE &&
       (st_q.sync2[0] ^ st_q.pol[0]) && !fail_safe_entry)
      |=> st_q.flags[0])
      else $error("Level wake on the first wake input did not set its flag.");

   AST_W2_CHANGE: assert property (@(posedge mclk) disable iff (sys_rst)
      (cyc_mode[1] && cyc_trig[1] && st_q.primed[1] &&
       st_q.cfg[3:2] != iowf_pkg::WCFG_NONE &&
       st_q.sync2[1] != st_q.flags[3] && !fail_safe_entry)
      |=> st_q.flags[1])
      else $error("Cyclic change on the second wake input was not flagged.");

   AST_FS_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
      fail_safe_entry |=> (st_q.flags & iowf_pkg::FLG_EVT_MASK) == 16'h0000)
      else $error("Fail-safe entry left an event flag set.");

   AST_W1_SAMPLE: assert property (@(posedge mclk) disable iff (sys_rst)
      cyc_trig[0] |=> st_q.flags[2] == $past(st_q.sync2[0]))
      else $error("First wake input sample was not captured at trigger.");

   AST_W2_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
      !cyc_trig[1] |=> $stable(st_q.flags[3]))
      else $error("Second wake input sample moved without a trigger.");

   AST_W1_READY: assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 st_q.flags[4] == $past(cyc_ready[0]))
      else $error("First wake input readiness does not follow its source.");

   AST_W2_READY: assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 st_q.flags[5] == $past(cyc_ready[1]))
      else $error("Second wake input readiness does not follow its source.");

   AST_HV1_CHANGE: assert property (@(posedge mclk) disable iff (sys_rst)
      (cyc_mode[2] && cyc_trig[2] && st_q.primed[2] &&
       st_q.cfg[5:4] != iowf_pkg::WCFG_NONE &&
       st_q.sync2[2] != st_q.flags[8] && !fail_safe_entry)
      |=> st_q.flags[6])
      else $error("Cyclic change on the first high-voltage I/O was lost.");

   AST_HV2_LEVEL: assert property (@(posedge mclk) disable iff (sys_rst)
      (!cyc_mode[3] && st_q.cfg[7:6] != iowf_pkg::WCFG_NONE &&
       (st_q.sync2[3] ^ st_q.pol[3]) && !fail_safe_entry)
      |=> st_q.flags[7])
      else $error("Level wake on the second high-voltage I/O was lost.");

   AST_HV1_SAMPLE: assert property (@(posedge mclk) disable iff (sys_rst)
      cyc_trig[2] |=> st_q.flags[8] == $past(st_q.sync2[2]))
      else $error("First high-voltage I/O sample was not captured.");

   AST_HV2_SAMPLE: assert property (@(posedge mclk) disable iff (sys_rst)
      cyc_trig[3] |=> st_q.flags[9] == $past(st_q.sync2[3]))
      else $error("Second high-voltage I/O sample was not captured.");

   AST_HV_READY: assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 st_q.flags[11:10] == $past(cyc_ready[3:2]))
      else $error("High-voltage I/O readiness does not follow its source.");

   AST_LV_NORMAL: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(st_q.flags[13]) |-> !$past(normal_mode))
      else $error("Low-voltage wake flag set while in Normal mode.");

   AST_LV_WAKE: assert property (@(posedge mclk) disable iff (sys_rst)
      (!normal_mode && (st_q.sync2[6] ^ st_q.pol[6]) &&
       st_q.cfg[13:12] != iowf_pkg::WCFG_NONE && !fail_safe_entry)
      |=> st_q.flags[15])
      else $error("Low-voltage input wake outside Normal mode was lost.");

   AST_ONLY_W1C: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(st_q.flags[14]) |->
         $past(fail_safe_entry) || $past(wr_done && pwdata[14]))
      else $error("An event flag fell without a clear.");

   AST_BIT12_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
      st_q.flags[12] == 1'b0 && prdata[31:16] == 16'h0000)
      else $error("An unused flag position read as one.");

   AST_IRQ_CAUSE: assert property (@(posedge mclk) disable iff (sys_rst)
      irq |-> (st_q.flags & st_q.mask & iowf_pkg::FLG_EVT_MASK) != 16'h0000)
      else $error("Interrupt raised with no unmasked event flag.");

   AST_APB_ONE_WAIT: assert property (@(posedge mclk) disable iff (sys_rst)
      (acc_phase && !pready) |=> pready ##1 !pready)
      else $error("Bus answer did not come after exactly one wait state.");

   // Remaining sources, then further fail-safe, clear, wake and config checks.

   AST_W1_CHANGE: assert property (@(posedge mclk) disable iff (sys_rst)
      (cyc_mode[0] && cyc_trig[0] && st_q.primed[0] &&
       st_q.cfg[1:0] != iowf_pkg::WCFG_NONE &&
       st_q.sync2[0] != st_q.flags[2] && !fail_safe_entry)
      |=> st_q.flags[0])
      else $error("Cyclic change on the first wake input was not flagged.");

   AST_W2_LEVEL: assert property (@(posedge mclk) disable iff (sys_rst)
      (!cyc_mode[1] && st_q.cfg[3:2] != iowf_pkg::WCFG_NONE &&
       (st_q.sync2[1] ^ st_q.pol[1]) && !fail_safe_entry)
      |=> st_q.flags[1])
      else $error("Level wake on the second wake input did not set its flag.");

   AST_W2_SAMPLE: assert property (@(posedge mclk) disable iff (sys_rst)
      cyc_trig[1] |=> st_q.flags[3] == $past(st_q.sync2[1]))
      else $error("Second wake input sample was not captured at trigger.");

   AST_FS_KEEPS_SAMPLE: assert property (@(posedge mclk) disable iff (sys_rst)
      (fail_safe_entry && !cyc_trig[0]) |=> $stable(st_q.flags[2]))
      else $error("Fail-safe entry disturbed a sampled pin state.");

   AST_HV1_LEVEL: assert property (@(posedge mclk) disable iff (sys_rst)
      (!cyc_mode[2] && st_q.cfg[5:4] != iowf_pkg::WCFG_NONE &&
       (st_q.sync2[2] ^ st_q.pol[2]) && !fail_safe_entry)
      |=> st_q.flags[6])
      else $error("Level wake on the first high-voltage I/O was lost.");

   AST_HV2_CHANGE: assert property (@(posedge mclk) disable iff (sys_rst)
      (cyc_mode[3] && cyc_trig[3] && st_q.primed[3] &&
       st_q.cfg[7:6] != iowf_pkg::WCFG_NONE &&
       st_q.sync2[3] != st_q.flags[9] && !fail_safe_entry)
      |=> st_q.flags[7])
      else $error("Cyclic change on the second high-voltage I/O was lost.");

   AST_HV2_READY: assert property (@(posedge mclk) disable iff (sys_rst)
      ##1 st_q.flags[11] == $past(cyc_ready[3]))
      else $error("Second high-voltage I/O readiness does not follow.");

   AST_LV3_WAKE: assert property (@(posedge mclk) disable iff (sys_rst)
      (!normal_mode && (st_q.sync2[4] ^ st_q.pol[4]) &&
       st_q.cfg[9:8] != iowf_pkg::WCFG_NONE && !fail_safe_entry)
      |=> st_q.flags[13])
      else $error("First low-voltage I/O wake outside Normal mode was lost.");

   AST_LV4_WAKE: assert property (@(posedge mclk) disable iff (sys_rst)
      (!normal_mode && (st_q.sync2[5] ^ st_q.pol[5]) &&
       st_q.cfg[11:10] != iowf_pkg::WCFG_NONE && !fail_safe_entry)
      |=> st_q.flags[14])
      else $error("Second low-voltage I/O wake outside Normal mode was lost.");

   AST_LV4_BLOCKED: assert property (@(posedge mclk) disable iff (sys_rst)
      (normal_mode && !st_q.flags[14]) |=> !st_q.flags[14])
      else $error("Low-voltage flag set while in Normal mode.");

   AST_CFG_NONE: assert property (@(posedge mclk) disable iff (sys_rst)
      (st_q.cfg[13:12] == iowf_pkg::WCFG_NONE && !st_q.flags[15])
      |=> !st_q.flags[15])
      else $error("An event flag set although its input is disabled.");

   AST_WAKE_CAUSE: assert property (@(posedge mclk) disable iff (sys_rst)
      wake_req |-> (st_q.flags & iowf_pkg::FLG_EVT_MASK) != 16'h0000)
      else $error("Wake request raised with no event flag set.");

   AST_W1C_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
      (wr_done && paddr == iowf_pkg::ADDR_FLAGS && pwdata[13] &&
       !(!normal_mode && (st_q.sync2[4] ^ st_q.pol[4]) &&
         st_q.cfg[9:8] != iowf_pkg::WCFG_NONE))
      |=> !st_q.flags[13])
      else $error("Writing one did not clear a low-voltage event flag.");

   AST_ZERO_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
      (wr_done && paddr == iowf_pkg::ADDR_FLAGS && !pwdata[0] &&
       !fail_safe_entry && st_q.flags[0])
      |=> st_q.flags[0])
      else $error("Writing zero cleared an event flag.");

endmodule : iowf_flags

// ### iowf_flags_bench.sv
// Self-checking bench for the wake-up flag register block.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module iowf_flags_bench;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic [6:0] wake_pin = 7'h00;
   logic [3:0] cyc_mode = 4'h0;
   logic [3:0] cyc_trig = 4'h0;
   logic [3:0] cyc_ready = 4'h0;
   logic normal_mode = 1'b0;
   logic fail_safe_entry = 1'b0;
   logic wake_req;
   logic irq;
   int miscompares = 0;
   int n_checks = 0;
   logic [32:0] exp_q [$];
   logic [32:0] got_e;
   logic [31:0] rexp;
   logic [31:0] exp;
   logic [3:0] rdy;

   always #5 mclk = ~mclk;

   iowf_flags #(.ADDR_W(8)) DUT (.mclk(mclk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .wake_pin(wake_pin), .cyc_mode(cyc_mode),
      .cyc_trig(cyc_trig), .cyc_ready(cyc_ready),
      .normal_mode(normal_mode), .fail_safe_entry(fail_safe_entry),
      .wake_req(wake_req), .irq(irq));

   task close_out;
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   // Read results are judged here, as the master takes them.
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) begin
            miscompares++;
         end else begin
            got_e = exp_q.pop_front();
            `CHK({pslverr, prdata}, got_e)
         end
      end
   end

   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   // One APB transfer; the request is held until pready is seen.
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         close_out();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task rd(input logic [7:0] a, input logic [31:0] e, input logic err);
      exp_q.push_back({err, e});
      xfer(1'b0, a, 32'h0);
   endtask : rd

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   // Pins pass a two-flop synchroniser, so a pulse is held long enough.
   task pulse(input logic [6:0] p);
      @(posedge mclk);
      wake_pin <= p;
      cyc(5);
      wake_pin <= 7'h00;
      cyc(4);
   endtask : pulse

   task trig;
      @(posedge mclk);
      cyc_trig <= 4'hf;
      @(posedge mclk);
      cyc_trig <= 4'h0;
      cyc(2);
   endtask : trig

   task do_reset;
      @(posedge mclk);
      sys_rst <= 1'b1;
      cyc(3);
      sys_rst <= 1'b0;
   endtask : do_reset

   initial begin
      repeat (100000) @(posedge mclk);
      miscompares++;
      close_out();
   end

   initial begin
      void'($urandom(51815));
      cyc(3);
      sys_rst <= 1'b0;
      rd(iowf_pkg::ADDR_FLAGS, 32'h0, 1'b0);
      rd(iowf_pkg::ADDR_CFG, 32'h00ff, 1'b0);
      rd(iowf_pkg::ADDR_MASK, 32'h0, 1'b0);
      rd(iowf_pkg::ADDR_POL, 32'h0, 1'b0);
      rd(8'h10, 32'h0, 1'b1);
      wr(8'h14, $urandom);
      wr(iowf_pkg::ADDR_MASK, 32'h0001);
      for (int c = 0; c < 4; c++) begin
         wr(iowf_pkg::ADDR_CFG, c);
         @(posedge mclk);
         wake_pin <= 7'h01;
         cyc(5);
         `CHK(wake_req, c[0] & (c != 0))
         `CHK(irq, c[1])
         wake_pin <= 7'h00;
         cyc(4);
         rd(iowf_pkg::ADDR_FLAGS, (c != 0), 1'b0);
         wr(iowf_pkg::ADDR_FLAGS, 32'h1);
         cyc(1);
         `CHK(irq, 1'b0)
      end
      wr(iowf_pkg::ADDR_CFG, 32'h3fff);
      normal_mode <= 1'b1;
      pulse(7'h70);
      rd(iowf_pkg::ADDR_FLAGS, 32'h0, 1'b0);
      normal_mode <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         pulse(7'h01 << i);
         exp = 32'h1 << iowf_pkg::EVT_BIT[i];
         wr(iowf_pkg::ADDR_FLAGS, 32'h0);
         rd(iowf_pkg::ADDR_FLAGS, exp, 1'b0);
         wr(iowf_pkg::ADDR_FLAGS, exp);
         rd(iowf_pkg::ADDR_FLAGS, 32'h0, 1'b0);
      end
      // Cyclic sense starts from a fresh reset, as the first trigger primes.
      do_reset();
      rdy = $urandom;
      rexp = 32'h0;
      for (int k = 0; k < 4; k++) begin
         rexp[iowf_pkg::RDY_BIT[k]] = rdy[k];
      end
      cyc_mode <= 4'hf;
      cyc_ready <= rdy;
      wake_pin <= 7'h0f;
      cyc(4);
      trig();
      rd(iowf_pkg::ADDR_FLAGS, 32'h030c | rexp, 1'b0);
      trig();
      rd(iowf_pkg::ADDR_FLAGS, 32'h030c | rexp, 1'b0);
      wake_pin <= 7'h00;
      cyc(4);
      trig();
      rd(iowf_pkg::ADDR_FLAGS, 32'h00c3 | rexp, 1'b0);
      wr(iowf_pkg::ADDR_FLAGS, 32'hffff);
      rd(iowf_pkg::ADDR_FLAGS, rexp, 1'b0);
      wake_pin <= 7'h0f;
      cyc(4);
      trig();
      rd(iowf_pkg::ADDR_FLAGS, 32'h03cf | rexp, 1'b0);
      @(posedge mclk);
      fail_safe_entry <= 1'b1;
      @(posedge mclk);
      fail_safe_entry <= 1'b0;
      cyc(1);
      rd(iowf_pkg::ADDR_FLAGS, 32'h030c | rexp, 1'b0);
      cyc(2);
      close_out();
   end
endmodule : iowf_flags_bench

// ### iowf_pkg.sv
// Constants shared by the wake-up flag register block.
package iowf_pkg;

   // APB byte addresses of the registers.
   localparam logic [7:0] ADDR_FLAGS = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_POL = 8'h0c;

   // Input count and the cyclic-sense capable subset.
   localparam int N_IN = 7;
   localparam int N_CYC = 4;

   // Flag register layout.
   localparam logic [15:0] FLG_EVT_MASK = 16'he0c3;
   localparam logic [15:0] FLG_RESET = 16'h0000;
   localparam int EVT_BIT [N_IN] = '{0, 1, 6, 7, 13, 14, 15};
   localparam int SMP_BIT [N_CYC] = '{2, 3, 8, 9};
   localparam int RDY_BIT [N_CYC] = '{4, 5, 10, 11};
   localparam int UNUSED_BIT = 12;

   // Wake and interrupt configuration, two bits per input.
   localparam int CFG_W = 2 * N_IN;
   localparam logic [13:0] CFG_RESET = 14'h00ff;
   localparam logic [13:0] CFG_FS_MASK = 14'h00ff;
   localparam logic [1:0] WCFG_NONE = 2'h0;
   localparam logic [1:0] WCFG_WAKE = 2'h1;
   localparam logic [1:0] WCFG_IRQ = 2'h2;
   localparam logic [1:0] WCFG_BOTH = 2'h3;
   localparam int WCFG_WAKE_BIT = 0;
   localparam int WCFG_IRQ_BIT = 1;

   // Interrupt mask and level polarity resets.
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [6:0] POL_RESET = 7'h00;

endpackage : iowf_pkg
